/* logic/plccfg_top.sv */
// Link configuration registers for the power-line slave, with controls
//
// The strobed register port was chosen for this implementation.
`default_nettype none
module plccfg_top
  import plccfg_pkg::*;
(
  input wire logic core_clk, // 200 MHz device clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  input wire logic line_below_sys, // Comparator, async pin
  input wire logic line_below_bat, // Comparator, async pin
  input wire logic system_undervoltage, // Undervoltage, async pin
  input wire logic line_supply, // Line supply present, async pin
  input wire logic [5:0] charger_limit, // Charger's own limit code
  input wire logic detect_fsm_en, // Master detection enabled
  input wire logic bulk_mode, // Bulk transfer mode active
  input wire logic poll_rx, // Poll packet received pulse
  input wire logic req_nack, // Master refused request pulse
  input wire logic req_ack, // Master accepted request pulse
  input wire logic pkt_nack, // Master refused packet pulse
  input wire logic pkt_ack, // Master accepted packet pulse
  output logic [5:0] current_limit_code, // Applied limit
  output logic discharge_en, // Line discharge path
  output logic line_watch, // Watch the line for traffic
  output logic connected, // Connected state
  output logic [2:0] dropout_select, // Dropout threshold select
  output logic [1:0] lower_window_select, // Lower window select
  output logic [1:0] upper_window_select, // Upper window select
  output logic req_retry, // Resend request pulse
  output logic pkt_retry, // Resend packet pulse
  output logic xfer_err // Transfer error pulse
);
  // Configuration registers, all host visible
  logic [7:0] curr_r; // line_current_limit_config
  logic [7:0] win_r; // line_voltage_window_config
  logic [7:0] rty_r; // line_link_retry_config
  logic [IRQ_N-1:0] sts_r; // Sticky interrupt status
  logic [IRQ_N-1:0] msk_r; // Interrupt mask, 1 enables
  logic [7:0] rdata_nxt; // Read mux result
  logic [IRQ_N-1:0] evt; // Event pulses this cycle
  logic [3:0] pin_in; // Raw async inputs
  logic [3:0] pin_s; // Filtered async inputs
  // Control path state
  logic [5:0] lim_nxt; // Next applied limit
  logic conn_nxt; // Next connected state
  logic [5:0] lim_r; // Applied limit register
  logic dsc_r; // Discharge output register
  logic watch_r; // Line watch register
  logic conn_r; // Connected register
  // Write address hits
  logic wr_curr; // Write hits current register
  logic wr_win; // Write hits window register
  logic wr_rty; // Write hits retry register

  plccfg_retry_if rif (); // Retry counter link

  // Async pins: three stages, change taken when stages 1 and 2 agree
  assign pin_in = {line_supply, system_undervoltage, line_below_bat,
    line_below_sys};
  // Pins idle low, so a zero reset value gives no false edge
  // Agreement of two stages filters single-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      logic [SYNC_N-1:0] sh_r; // Synchroniser stages
      logic val_r; // Accepted level
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          sh_r <= '0;
        else
          sh_r <= {sh_r[SYNC_N-2:0], pin_in[gi]};
      end
      // Stage 0 is read only by stage 1, avoiding metastable fan-out
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          val_r <= 1'b0;
        else if (sh_r[1] == sh_r[2])
          val_r <= sh_r[2];
      end
      assign pin_s[gi] = val_r;
    end
  endgenerate

  // Write decode
  // Unmapped writes fall through and change nothing
  assign wr_curr = reg_wr && (reg_addr == OFS_CURR);
  assign wr_win = reg_wr && (reg_addr == OFS_WIN);
  assign wr_rty = reg_wr && (reg_addr == OFS_RTY);

  // Current limit config register
  // Written whole; all eight bits are read-write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      curr_r <= RST_CURR;
    else if (wr_curr)
      curr_r <= reg_wdata;
  end

  // Voltage window config register
  // Fields feed the analog window selects directly
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      win_r <= RST_WIN;
    else if (wr_win)
      win_r <= reg_wdata;
  end

  // Retry config register
  // New codes apply from the next refusal onward
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rty_r <= RST_RTY;
    else if (wr_rty)
      rty_r <= reg_wdata;
  end

  // Interrupt mask register
  // A set mask bit lets its source raise irq
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      msk_r <= RST_MSK[IRQ_N-1:0];
    else if (reg_wr && reg_addr == OFS_IRQ_MSK)
      msk_r <= reg_wdata[IRQ_N-1:0];
  end

  // Sticky status: write one clears, a same-cycle event wins
  // Losing an event to a clear would hide an error for good
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sts_r <= '0;
    else if (reg_wr && reg_addr == OFS_IRQ_STS)
      sts_r <= (sts_r & ~reg_wdata[IRQ_N-1:0]) | evt;
    else
      sts_r <= sts_r | evt;
  end

  // Level interrupt from unmasked status
  // Registered so irq never glitches on bus decode
  // Costs one cycle of latency after the status bit
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(sts_r & msk_r);
  end

  // Applied current limit
  // Force overrides everything, minimise next, then charger
  // The charger may only lower the limit, never raise it
  always_comb
  begin
    if (curr_r[B_FORCE])
      lim_nxt = curr_r[5:0];
    else if (curr_r[B_MIN] && (pin_s[0] || pin_s[1]))
      lim_nxt = CURR_MIN;
    else if (charger_limit < curr_r[5:0])
      lim_nxt = charger_limit;
    else
      lim_nxt = curr_r[5:0];
  end

  // Applied limit register; zero for one edge after reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      lim_r <= 6'h00;
    else
      lim_r <= lim_nxt;
  end

  // Discharge path and line watching
  // Both follow the filtered pins, so they lag the pin
  // by four to five cycles
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dsc_r <= 1'b0;
      watch_r <= 1'b0;
    end
    else
    begin
      dsc_r <= pin_s[2] && win_r[B_DSC];
      // Detection FSM owns the line when it is enabled
      watch_r <= !detect_fsm_en && !rty_r[B_MON] && pin_s[3];
    end
  end

  // Connection state; supply loss always disconnects
  // Policy 1 needs no packet; policy 0 waits for a poll
  // The connect event fires on the 0 to 1 step
  always_comb
  begin
    if (!pin_s[3])
      conn_nxt = 1'b0;
    else if (rty_r[B_CONP])
      conn_nxt = 1'b1;
    else if (poll_rx)
      conn_nxt = 1'b1;
    else
      conn_nxt = conn_r;
  end

  // Connected state register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      conn_r <= 1'b0;
    else
      conn_r <= conn_nxt;
  end

  // Retry counter hookup
  // Only the refusal codes, bulk mode and live strobes cross over
  assign rif.req_code = rty_r[B_REQ_LSB+2:B_REQ_LSB];
  assign rif.pkt_code = rty_r[B_PKT_LSB+2:B_PKT_LSB];
  assign rif.bulk = bulk_mode;
  assign rif.req_nack = req_nack;
  assign rif.req_ack = req_ack;
  assign rif.pkt_nack = pkt_nack;
  assign rif.pkt_ack = pkt_ack;

  plccfg_retry u_retry (
    .core_clk (core_clk),
    .rst_b (rst_b),
    .rif (rif.cnt)
  );

  // Events into status
  // Error pulses come straight from the counters
  // Connect event is the rising step of the connected state
  always_comb
  begin
    evt = '0;
    evt[IRQ_REQ_ERR] = rif.req_err;
    evt[IRQ_PKT_ERR] = rif.pkt_err;
    evt[IRQ_CONN] = conn_nxt && !conn_r;
  end

  // Read mux; unmapped addresses read zero
  // Status and mask read back in the low bits
  always_comb
  begin
    unique case (reg_addr)
      OFS_CURR: rdata_nxt = curr_r;
      OFS_WIN: rdata_nxt = win_r;
      OFS_RTY: rdata_nxt = rty_r;
      OFS_IRQ_STS: rdata_nxt = {5'h00, sts_r};
      OFS_IRQ_MSK: rdata_nxt = {5'h00, msk_r};
      OFS_LINK_STS: rdata_nxt = {conn_r, watch_r, lim_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered, valid only the cycle after the strobe
  // Zero between reads, so stale data never lingers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end

  // Outputs
  // Window fields are passed out as stored
  // Either counter's error drives the one error pulse
  assign current_limit_code = lim_r;
  assign discharge_en = dsc_r;
  assign line_watch = watch_r;
  assign connected = conn_r;
  assign dropout_select = win_r[6:4];
  assign lower_window_select = win_r[3:2];
  assign upper_window_select = win_r[1:0];
  assign req_retry = rif.req_retry;
  assign pkt_retry = rif.pkt_retry;
  assign xfer_err = rif.req_err || rif.pkt_err;
endmodule : plccfg_top
`default_nettype wire

/* logic/plccfg_pkg.sv */
// Package: offsets, fields and reset values of the link config registers
`default_nettype none
package plccfg_pkg;
  localparam int ADDR_W = 8; // Register address width
  // Register offsets
  localparam logic [7:0] OFS_CURR = 8'h32; // line_current_limit_config
  localparam logic [7:0] OFS_WIN = 8'h33; // line_voltage_window_config
  localparam logic [7:0] OFS_RTY = 8'h34; // line_link_retry_config
  localparam logic [7:0] OFS_IRQ_STS = 8'h38; // Interrupt status, W1C
  localparam logic [7:0] OFS_IRQ_MSK = 8'h39; // Interrupt mask
  localparam logic [7:0] OFS_LINK_STS = 8'h3a; // Live link state
  // Reset values
  localparam logic [7:0] RST_CURR = 8'hbf; // Minimise on, force off, 0x3f
  localparam logic [7:0] RST_WIN = 8'ha5; // Discharge 1, drop 2, 1, 1
  localparam logic [7:0] RST_RTY = 8'h3f; // Retry codes 7 and 7
  localparam logic [7:0] RST_MSK = 8'h00; // All interrupts masked
  // Field positions
  localparam int B_MIN = 7; // Minimise bit
  localparam int B_FORCE = 6; // Force-limit bit
  localparam int B_DSC = 7; // Discharge enable
  localparam int B_MON = 7; // Monitor disable
  localparam int B_CONP = 6; // Connection policy
  localparam int B_REQ_LSB = 3; // Request refusal code lsb
  localparam int B_PKT_LSB = 0; // Packet retry code lsb
  // Interrupt status bit positions
  localparam int IRQ_REQ_ERR = 0; // Request refusal limit reached
  localparam int IRQ_PKT_ERR = 1; // Packet retry limit reached
  localparam int IRQ_CONN = 2; // Connected state entered
  localparam int IRQ_N = 3; // Number of interrupt sources
  localparam logic [5:0] CURR_MIN = 6'h00; // Minimum limit code
  localparam int SYNC_N = 3; // Pin synchroniser depth
endpackage : plccfg_pkg
`default_nettype wire

/* logic/plccfg_retry_if.sv */
// Interface: retry counter controls and results
`default_nettype none
interface plccfg_retry_if;
  logic [2:0] req_code; // Request refusal code
  logic [2:0] pkt_code; // Packet retry code
  logic bulk; // Bulk mode
  logic req_nack; // Request refused
  logic req_ack; // Request accepted
  logic pkt_nack; // Packet refused
  logic pkt_ack; // Packet accepted
  logic req_err; // Request error pulse
  logic pkt_err; // Packet error pulse
  logic pkt_retry; // Resend packet pulse
  logic req_retry; // Resend request pulse
  modport top (output req_code, pkt_code, bulk, req_nack, req_ack,
    pkt_nack, pkt_ack, input req_err, pkt_err, pkt_retry, req_retry);
  modport cnt (input req_code, pkt_code, bulk, req_nack, req_ack,
    pkt_nack, pkt_ack, output req_err, pkt_err, pkt_retry, req_retry);
endinterface : plccfg_retry_if
`default_nettype wire

/* logic/plccfg_retry.sv */
// Retry counters for bulk data-output requests and data packets
`default_nettype none
module plccfg_retry
  import plccfg_pkg::*;
(
  input wire logic core_clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  plccfg_retry_if.cnt rif // Counter controls
);
  logic [7:0] req_cnt_r; // Refusals of current request
  logic [2:0] pkt_cnt_r; // Refusals of current packet
  logic [7:0] req_lim; // 2**code refusals allowed
  logic req_last; // This refusal hits the limit
  logic pkt_last; // This refusal hits the limit

  // Limits decoded from the codes
  assign req_lim = 8'h01 << rif.req_code;
  assign req_last = (req_cnt_r + 8'h01) >= req_lim;
  assign pkt_last = pkt_cnt_r >= rif.pkt_code;

  // Request refusal counter; outside bulk mode refusals are ignored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      req_cnt_r <= 8'h00;
    else if (rif.req_ack || !rif.bulk)
      req_cnt_r <= 8'h00;
    else if (rif.req_nack)
    begin
      if (req_last)
        req_cnt_r <= 8'h00; // Item abandoned, start fresh
      else
        req_cnt_r <= req_cnt_r + 8'h01;
    end
  end

  // Packet refusal counter, code+1 tries in total
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pkt_cnt_r <= 3'h0;
    else if (rif.pkt_ack || !rif.bulk)
      pkt_cnt_r <= 3'h0;
    else if (rif.pkt_nack)
    begin
      if (pkt_last)
        pkt_cnt_r <= 3'h0;
      else
        pkt_cnt_r <= pkt_cnt_r + 3'h1;
    end
  end

  // Outcome pulses, combinational from the refusal strobe
  assign rif.req_err = rif.bulk && rif.req_nack && !rif.req_ack
    && req_last;
  assign rif.req_retry = rif.bulk && rif.req_nack && !rif.req_ack
    && !req_last;
  assign rif.pkt_err = rif.bulk && rif.pkt_nack && !rif.pkt_ack
    && pkt_last;
  assign rif.pkt_retry = rif.bulk && rif.pkt_nack && !rif.pkt_ack
    && !pkt_last;
endmodule : plccfg_retry
`default_nettype wire

/* test/plccfg_top_assertions.sv */
// Checker: register shadows and refusal counters beside the top ports
`default_nettype none
module plccfg_top_assertions
  import plccfg_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic line_below_sys, // Comparator
  input wire logic system_undervoltage, // Undervoltage
  input wire logic line_supply, // Supply
  input wire logic [5:0] charger_limit, // Charger limit
  input wire logic detect_fsm_en, // Detection on
  input wire logic bulk_mode, // Bulk mode
  input wire logic req_nack, // Request refused
  input wire logic req_ack, // Request accepted
  input wire logic pkt_nack, // Packet refused
  input wire logic pkt_ack, // Packet accepted
  input wire logic [5:0] current_limit_code, // Applied limit
  input wire logic discharge_en, // Discharge
  input wire logic line_watch, // Watch
  input wire logic connected, // Connected
  input wire logic req_retry, // Request resend
  input wire logic pkt_retry, // Packet resend
  input wire logic xfer_err // Error
);
  logic [7:0] c_r, t_r; // Current and retry shadows
  logic w_r; // Discharge enable shadow
  logic [7:0] rq_r; // Request refusals in a row
  logic [2:0] pk_r; // Packet refusals in a row
  wire logic rq_tk = req_nack && bulk_mode && !req_ack; // Refusal taken
  wire logic pk_tk = pkt_nack && bulk_mode && !pkt_ack; // Refusal taken
  wire logic rq_hit = rq_tk && {1'b0, rq_r} + 9'h001 == 9'h001 << t_r[5:3];
  wire logic pk_hit = pk_tk && pk_r == t_r[2:0]; // Last allowed refusal
  // Shadows follow host writes so checks know the programmed fields
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      c_r <= RST_CURR;
      t_r <= RST_RTY;
      w_r <= RST_WIN[B_DSC];
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_CURR) c_r <= reg_wdata;
      if (reg_addr == OFS_RTY) t_r <= reg_wdata;
      if (reg_addr == OFS_WIN) w_r <= reg_wdata[B_DSC];
    end
  // Counts restart on acknowledge, on the limit and outside bulk mode
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      rq_r <= 8'h00;
      pk_r <= 3'h0;
    end
    else
    begin
      if (!bulk_mode || req_ack || rq_hit) rq_r <= 8'h00;
      else if (rq_tk) rq_r <= rq_r + 8'h01;
      if (!bulk_mode || pkt_ack || pk_hit) pk_r <= 3'h0;
      else if (pk_tk) pk_r <= pk_r + 3'h1;
    end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_force;
    c_r[B_FORCE] && c_r == $past(c_r) |-> current_limit_code == c_r[5:0];
  endproperty
  a_force: assert property (p_force) else $error("forced limit");
  property p_lower;
    !c_r[B_FORCE] && !c_r[B_MIN] && c_r == $past(c_r) &&
      $stable(charger_limit) |-> current_limit_code ==
      (c_r[5:0] < charger_limit ? c_r[5:0] : charger_limit);
  endproperty
  a_lower: assert property (p_lower) else $error("lowered limit");
  property p_min;
    (c_r[B_MIN] && !c_r[B_FORCE] && line_below_sys)[*8] |->
      current_limit_code == CURR_MIN;
  endproperty
  a_min: assert property (p_min) else $error("minimum limit");
  property p_dsc;
    (w_r == $past(w_r) && $stable(system_undervoltage))[*8] |->
      discharge_en == (w_r && system_undervoltage);
  endproperty
  a_dsc: assert property (p_dsc) else $error("discharge");
  property p_watch;
    ($stable(line_supply) && $stable(detect_fsm_en) && $stable(t_r))[*8]
      |-> line_watch == (line_supply && !detect_fsm_en && !t_r[B_MON]);
  endproperty
  a_watch: assert property (p_watch) else $error("line watch");
  property p_conn;
    (line_supply && t_r[B_CONP])[*8] |-> connected;
  endproperty
  a_conn: assert property (p_conn) else $error("connect");
  property p_req;
    rq_tk |-> req_retry == !rq_hit;
  endproperty
  a_req: assert property (p_req) else $error("request resend");
  property p_pkt;
    pk_tk |-> pkt_retry == !pk_hit;
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet resend");
  property p_err;
    xfer_err == (rq_hit || pk_hit);
  endproperty
  a_err: assert property (p_err) else $error("transfer error");
endmodule : plccfg_top_assertions
bind plccfg_top plccfg_top_assertions u_plccfg_top_assertions (.core_clk,
  .rst_b, .reg_addr, .reg_wdata, .reg_wr, .line_below_sys,
  .system_undervoltage, .line_supply, .charger_limit, .detect_fsm_en,
  .bulk_mode, .req_nack, .req_ack, .pkt_nack, .pkt_ack, .current_limit_code,
  .discharge_en, .line_watch, .connected, .req_retry, .pkt_retry, .xfer_err);
`default_nettype wire

/* test/plccfg_master_model.sv */
// Line master model: one poll, acknowledge or refusal pulse on request
`default_nettype none
module plccfg_master_model
(
  input wire logic core_clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  input wire logic go, // Start one answer
  input wire logic [2:0] kind, // Pulse index to raise
  input wire logic [3:0] gap, // Cycles before the answer
  output logic [4:0] pulse // Packet ack/nack, request ack/nack, poll
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r; // Remaining delay
  logic [2:0] kind_r; // Pending answer
  logic busy_r; // Answer pending
  // Variable delay so slow answers test that counts hold between pulses
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      kind_r <= 3'h0;
      pulse <= 5'h00;
    end
    else
    begin
      pulse <= 5'h00;
      if (go)
      begin
        busy_r <= 1'b1;
        wait_r <= gap;
        kind_r <= kind;
      end
      else if (busy_r && wait_r == 4'h0)
      begin
        busy_r <= 1'b0;
        pulse <= 5'h01 << kind_r;
      end
      else if (busy_r)
        wait_r <= wait_r - 4'h1;
    end
endmodule : plccfg_master_model
`default_nettype wire

/* test/plccfg_top_bench.sv */
// Bench: registers, controls and retry counts against a master model
`default_nettype none
module plccfg_top_bench
  import plccfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_b = 1'b0; // Clock, reset
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata; // Bus
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq; // Strobes, interrupt
  logic line_below_sys = 1'b0, line_below_bat = 1'b0; // Comparators
  logic system_undervoltage = 1'b0, line_supply = 1'b0; // Supply pins
  logic [5:0] charger_limit = 6'h3f, current_limit_code; // Limits
  logic detect_fsm_en = 1'b0, bulk_mode = 1'b0; // Modes
  wire logic poll_rx, req_nack, req_ack, pkt_nack, pkt_ack; // Master
  logic discharge_en, line_watch, connected, req_retry, pkt_retry, xfer_err;
  logic [2:0] dropout_select; // Window fields
  logic [1:0] lower_window_select, upper_window_select;
  logic go = 1'b0, lv = 1'b0, rd_d = 1'b0; // Model start, notes
  logic [2:0] kind = 3'h0; // Answer kind
  logic [3:0] gap = 4'h0; // Answer delay
  logic e_dsc = 1'b0, e_wat = 1'b0, e_con = 1'b0, e_irq = 1'b0; // Expected
  logic [5:0] e_cl = 6'h3f; // Expected limit
  logic [6:0] e_win = RST_WIN[6:0]; // Expected window fields
  logic [31:0] seed = 32'h3cf69435; // Random state
  logic [7:0] rdq[$]; // Read notes
  logic [2:0] evq[$]; // Pulse notes
  logic [16:0] lq[$]; // Level notes
  int sk[8] = '{1, 2, 1, 3, 4, 3, 1, 3}; // Interleaved answers
  int se[8] = '{4, 0, 4, 2, 0, 2, 1, 1}; // Their pulses
  int fail_count = 0, checks_done = 0; // Counters
  plccfg_top u_plccfg_top (.core_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .line_below_sys, .line_below_bat,
    .system_undervoltage, .line_supply, .charger_limit, .detect_fsm_en,
    .bulk_mode, .poll_rx, .req_nack, .req_ack, .pkt_nack, .pkt_ack,
    .current_limit_code, .discharge_en, .line_watch, .connected,
    .dropout_select, .lower_window_select, .upper_window_select,
    .req_retry, .pkt_retry, .xfer_err);
  plccfg_master_model u_plccfg_master_model (.core_clk, .rst_b, .go, .kind,
    .gap, .pulse({pkt_ack, pkt_nack, req_ack, req_nack, poll_rx}));
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string n, input logic [16:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    rdq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // Level note after the pin synchronisers have settled
  task automatic lvl();
    repeat (10) @(posedge core_clk);
    lq.push_back({e_dsc, e_wat, e_con, e_irq, e_cl, e_win});
    lv <= 1'b1;
    @(posedge core_clk);
    lv <= 1'b0;
    @(posedge core_clk);
  endtask : lvl
  task automatic master(input logic [2:0] k, input logic [3:0] g, e);
    if (k == 3'd1 || k == 3'd3) evq.push_back(e[2:0]);
    kind <= k;
    gap <= g;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (g + 4) @(posedge core_clk);
  endtask : master
  // Result side takes the oldest note whenever a result shows
  always @(posedge core_clk)
  begin
    if (rd_d)
      check("reg_rdata", 17'(reg_rdata), 17'(rdq.pop_front()));
    rd_d = reg_rd;
    if (req_nack || pkt_nack)
      check("pulses", 17'({req_retry, pkt_retry, xfer_err}),
        17'(evq.pop_front()));
    if (lv)
      check("levels", {discharge_en, line_watch, connected, irq,
        current_limit_code, dropout_select, lower_window_select,
        upper_window_select}, lq.pop_front());
  end
  // Hang guard, far beyond the expected run length
  initial
  begin
    #400us;
    fail_count++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset values, then an unmapped place reads zero
    rd(OFS_CURR, RST_CURR);
    rd(OFS_WIN, RST_WIN);
    rd(OFS_RTY, RST_RTY);
    rd(OFS_IRQ_MSK, RST_MSK);
    rd(8'h3f, 8'h00);
    lvl();
    // Random window fields; discharge follows its enable
    seed = lfsr(seed);
    system_undervoltage <= 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      wr(OFS_WIN, {b[0], seed[6:0]});
      e_win = seed[6:0];
      e_dsc = b[0];
      lvl();
    end
    rd(OFS_WIN, {1'b1, seed[6:0]});
    system_undervoltage <= 1'b0;
    e_dsc = 1'b0;
    // Plain, forced, minimised and forced-minimised limit
    seed = lfsr(seed);
    charger_limit <= seed[13:8];
    line_below_sys <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_CURR, {m[1:0], seed[5:0]});
      e_cl = m[0] ? seed[5:0] : m[1] ? CURR_MIN :
        (seed[5:0] < seed[13:8] ? seed[5:0] : seed[13:8]);
      lvl();
    end
    line_below_sys <= 1'b0;
    // Battery comparator alone also minimises
    line_below_bat <= 1'b1;
    wr(OFS_CURR, {2'b10, seed[5:0]});
    e_cl = CURR_MIN;
    lvl();
    line_below_bat <= 1'b0;
    wr(OFS_CURR, {2'b01, seed[5:0]});
    e_cl = seed[5:0];
    // Watch and connect policy against supply, detection and poll
    line_supply <= 1'b1;
    e_wat = 1'b1;
    lvl();
    wr(OFS_RTY, 8'hbf);
    e_wat = 1'b0;
    lvl();
    detect_fsm_en <= 1'b1;
    wr(OFS_RTY, 8'h3f);
    lvl();
    detect_fsm_en <= 1'b0;
    master(3'd0, 4'd2, 3'h0);
    e_con = 1'b1;
    e_wat = 1'b1;
    lvl();
    line_supply <= 1'b0;
    e_con = 1'b0;
    e_wat = 1'b0;
    lvl();
    wr(OFS_RTY, 8'h7f);
    line_supply <= 1'b1;
    e_con = 1'b1;
    e_wat = 1'b1;
    lvl();
    rd(OFS_LINK_STS, {e_con, e_wat, e_cl});
    // Refusal bursts for every code of both counters
    bulk_mode <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(OFS_RTY, {2'b01, c[2:0], c[2:0]});
      for (int i = 1; i <= (1 << c); i++)
        master(3'd1, i[3:0], (i == (1 << c)) ? 3'b001 : 3'b100);
      for (int i = 0; i <= c; i++)
        master(3'd3, 4'd0, (i == c) ? 3'b001 : 3'b010);
    end
    // Acknowledge restarts a count; the two counts stay apart
    wr(OFS_RTY, 8'h49);
    foreach (sk[i]) master(sk[i][2:0], 4'd1, se[i][2:0]);
    bulk_mode <= 1'b0;
    master(3'd1, 4'd0, 3'b000);
    // Interrupt masked, unmasked, then cleared by writing ones
    rd(OFS_IRQ_STS, 8'h07);
    lvl();
    wr(OFS_IRQ_MSK, 8'h03);
    e_irq = 1'b1;
    lvl();
    wr(OFS_IRQ_STS, 8'h03);
    e_irq = 1'b0;
    lvl();
    rd(OFS_IRQ_STS, 8'h04);
    stop_test();
  end
endmodule : plccfg_top_bench
`default_nettype wire
